/* verilog/lpmc_map.svh */
// register offsets, field positions, reset values and timing counts of the low power mode controller
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH
`define LPMC_OFS_CTRL        4'h0
`define LPMC_OFS_STATUS      4'h4
`define LPMC_OFS_OPTION      4'h8
`define LPMC_OFS_IRQCFG      4'hc
`define LPMC_CTRL_AUX_BIT    0
`define LPMC_CTRL_GIE_BIT    1
`define LPMC_OPT_OVR_BIT     0
`define LPMC_OPT_WDG_BIT     1
`define LPMC_CTRL_RESET      8'h00
`define LPMC_OPTION_RESET    8'h00
`define LPMC_IRQCFG_RESET    8'h00
`define LPMC_SETTLE_CYCLES   2048
`define LPMC_PER_IRQS        4
`endif

/* verilog/lpmc_pkg.sv */
// types shared by the low power mode controller
package lpmc_pkg;
    typedef enum logic [2:0] {
        LPMC_RUN    = 3'b000,
        LPMC_WAIT   = 3'b001,
        LPMC_STOP   = 3'b010,
        LPMC_SETTLE = 3'b011,
        LPMC_WAKE   = 3'b100
    } lpmc_state_e;
    typedef enum logic [1:0] {
        LPMC_CTX_MAIN = 2'b00,
        LPMC_CTX_IRQ  = 2'b01,
        LPMC_CTX_NMI  = 2'b10
    } lpmc_ctx_e;
endpackage

/* verilog/lpmc_settle_timer.sv */
// oscillator settling counter used on every exit from stop
`timescale 1ns/1ps
`include "lpmc_map.svh"
module lpmc_settle_timer #(
    parameter int CYCLES = `LPMC_SETTLE_CYCLES
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic start,
    output logic      done
);
    logic [15:0] count;
    logic        busy;
    wire         last = busy && (count == 16'(CYCLES - 1));

    // counts CYCLES clock edges after start, then pulses done once
    always_ff @(posedge clk) begin
        if (sys_rst || start) begin
            count <= 16'h0000;
            busy  <= start && !sys_rst;
        end else if (busy) begin
            count <= count + 16'h0001;
            busy  <= !last;
        end
    end

    assign done = last;
endmodule

/* verilog/lpmc_core.sv */
// low power mode controller: run, wait and stop sequencing with wake and restart context
//
// Overview of operation
// (R1) reset lands in run, main clock master
// (R2) wait instruction freezes cpu, peripherals run
// (R3) state kept in wait and stop
// (R4) active oscillator keeps running during wait
// (R5) wait exits on reset or interrupt, vectored
// (R6) stop halts execution and the oscillator
// (R7) stop exits on reset, ext, nmi, extclk
// (R8) stop exit waits 2048 cycles before fetch
// (R9) watchdog turns stop into wait, override excepted
// (R10) nmi without global enable never wakes
// (R11) main context: isr first, then next instruction
// (R12) nmi context: continue after sleep, no interrupt
// (R13) irq context, maskable wake: resume routine first
// (R14) irq context, nmi wake: nmi handler first
// (R15) sleep ignored while enabled request pending
// (R16) software enables auxiliary oscillator before wait
// (R17) software sets global enable to allow interrupts
// (R18) wait exit has no settling delay
// (R19) maskable wake needs global and source enable
`timescale 1ns/1ps
`include "lpmc_map.svh"
module lpmc_core
    import lpmc_pkg::*;
#(
    parameter int NPER = `LPMC_PER_IRQS
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // avalon-mm slave
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    // cpu core side
    input  wire logic             wait_insn,
    input  wire logic             stop_insn,
    input  wire logic [1:0]       cpu_ctx,
    // interrupt sources
    input  wire logic             nmi_req,
    input  wire logic             nmi_pin,
    input  wire logic             ext_irq,
    input  wire logic [NPER-1:0]  per_irq,
    input  wire logic [NPER-1:0]  per_ext_clk,
    input  wire logic             wdg_active,
    // clock and cpu control
    output logic                  cpu_clk_en,
    output logic                  periph_clk_en,
    output logic                  osc_en,
    output logic                  low_freq_aux_oscillator,
    output logic                  wdg_freeze,
    output logic                  wake_pulse,
    output logic                  wake_take_irq,
    output logic                  wake_take_nmi,
    output logic                  wake_resume,
    output logic                  sleep_ignored
);
    // sequencer state, sleep context and the software registers
    lpmc_state_e state;
    lpmc_state_e next_state;
    lpmc_ctx_e   sleep_ctx;
    logic [7:0]  ctrl;
    logic [7:0]  option;
    logic [7:0]  irqcfg;
    // sequencer to settling counter handshake and bus read strobe
    logic        pending_stop;
    logic        settle_start;
    logic        settle_done;
    logic        rd_ack;
    logic [2:0]  nmi_sync;

    // nmi pin comes from outside the clock domain
    // the first stage may go metastable; only the later two are read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_sync <= 3'h0;
        end else begin
            nmi_sync <= {nmi_sync[1:0], nmi_pin};
        end
    end

    // filtered nmi level: only a value seen by both late stages counts,
    // so a pin moving near the clock edge cannot flicker the override
    logic nmi_pin_level;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_pin_level <= 1'b0;
        end else if (nmi_sync[1] == nmi_sync[2]) begin
            nmi_pin_level <= nmi_sync[2];
        end
    end

    // register decode
    wire global_irq_enable    = ctrl[`LPMC_CTRL_GIE_BIT];
    wire stop_override_option = option[`LPMC_OPT_OVR_BIT];
    // address decode on the byte offset, one register per word
    wire sel_ctrl   = avs_address == `LPMC_OFS_CTRL;
    wire sel_status = avs_address == `LPMC_OFS_STATUS;
    wire sel_option = avs_address == `LPMC_OFS_OPTION;
    wire sel_irqcfg = avs_address == `LPMC_OFS_IRQCFG;
    wire wr_lane0   = avs_write && avs_byteenable[0];

    // only byte lane 0 carries register bits; the upper lanes read as zero
    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] wd, input logic be);
        lane_merge = be ? wd[7:0] : old;
    endfunction

    // maskable sources qualify only when globally and individually enabled
    // bit NPER of the source enables belongs to the external line
    wire [NPER-1:0] per_enabled = per_irq & irqcfg[NPER-1:0];              // [R19]
    wire ext_enabled   = ext_irq & irqcfg[NPER];                          // [R19]
    wire mask_req      = global_irq_enable && (|per_enabled || ext_enabled); // [R19]
    // in stop only sources with their own clock survive
    wire mask_stop_req = global_irq_enable && (ext_enabled || |(per_enabled & per_ext_clk)); // [R7]
    // nmi wakes only while the global enable is set
    // it is still serviced in run; only the wake is blocked
    wire nmi_wake      = nmi_req && global_irq_enable;                    // [R10]
    wire wait_wake     = mask_req || nmi_wake;                            // [R5]
    wire stop_wake     = mask_stop_req || nmi_wake;                       // [R7]
    // any enabled request refuses a sleep instruction in the same cycle
    wire pending_any   = mask_req || nmi_wake;
    // wait and stop share the entry checks; stop_insn picks the target
    wire sleep_req     = wait_insn || stop_insn;
    // watchdog forces stop down to wait unless overridden with nmi pin high
    wire stop_allowed  = !wdg_active || (stop_override_option && nmi_pin_level); // [R9]
    wire go_stop       = stop_insn && stop_allowed;
    // the pin level used here lags the pin by about four clocks

    // state transition
    // no state is skipped: stop always passes through settle
    always_comb begin
        next_state   = state;
        settle_start = 1'b0;
        case (state)
            // run: enter sleep only with nothing enabled pending
            LPMC_RUN: begin
                if (sleep_req && !pending_any) begin                      // [R15]
                    next_state = go_stop ? LPMC_STOP : LPMC_WAIT;         // [R2] [R6] [R9]
                end
            end
            // wait: oscillator still running, so wake goes straight to restart
            LPMC_WAIT: begin
                if (wait_wake) begin
                    next_state = LPMC_WAKE;                               // [R18]
                end
            end
            // stop: any surviving source starts the settling count
            LPMC_STOP: begin
                if (stop_wake) begin
                    next_state   = LPMC_SETTLE;
                    settle_start = 1'b1;                                  // [R8]
                end
            end
            // settle: cpu held until the oscillator has had its count
            LPMC_SETTLE: begin
                if (settle_done) begin
                    next_state = LPMC_WAKE;                               // [R8]
                end
            end
            // wake: one cycle, so the restart flags pulse once, the cycle after clock return
            LPMC_WAKE: begin
                next_state = LPMC_RUN;
            end
            // unused codes fall back to run rather than lock up
            default: begin
                next_state = LPMC_RUN;
            end
        endcase
    end

    // reset always lands in run
    // reset is synchronous, so a wake by reset is simply this branch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= LPMC_RUN;                                            // [R1]
        end else begin
            state <= next_state;
        end
    end

    // remember context and which wake source arrived
    // the cpu is frozen while asleep, so its context is taken on the entry edge
    logic wake_by_nmi;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_ctx    <= LPMC_CTX_MAIN;
            wake_by_nmi  <= 1'b0;
            pending_stop <= 1'b0;
        end else begin
            if (state == LPMC_RUN && next_state != LPMC_RUN) begin
                sleep_ctx    <= lpmc_ctx_e'(cpu_ctx);
                pending_stop <= next_state == LPMC_STOP;
            end
            // nmi wins when both kinds arrive together, having higher priority
            if ((state == LPMC_WAIT && wait_wake) || (state == LPMC_STOP && stop_wake)) begin
                wake_by_nmi <= nmi_wake;
            end
        end
    end

    // settling counter, restarted on every stop exit
    lpmc_settle_timer #(
        .CYCLES (`LPMC_SETTLE_CYCLES)
    ) u_settle (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (settle_start),
        .done    (settle_done)
    );

    // restart decision, one cycle pulse in wake state
    // exactly one of the three restart flags goes with each wake pulse when the saved context is main, irq or nmi
    wire in_wake = state == LPMC_WAKE;
    wire ctx_main = sleep_ctx == LPMC_CTX_MAIN;
    wire ctx_nmi  = sleep_ctx == LPMC_CTX_NMI;
    wire ctx_irq  = sleep_ctx == LPMC_CTX_IRQ;
    wire next_take_nmi = in_wake && wake_by_nmi && !ctx_nmi;               // [R14] [R11]
    wire next_take_irq = in_wake && !wake_by_nmi && ctx_main;              // [R11]
    // nmi context and maskable wake in irq context go straight on
    wire next_resume   = in_wake && (ctx_nmi || (ctx_irq && !wake_by_nmi)); // [R12] [R13]

    // restart flags and the refusal strobe are registered one-cycle pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_pulse    <= 1'b0;
            wake_take_irq <= 1'b0;
            wake_take_nmi <= 1'b0;
            wake_resume   <= 1'b0;
            sleep_ignored <= 1'b0;
        end else begin
            wake_pulse    <= in_wake;                                     // [R5]
            wake_take_irq <= next_take_irq;
            wake_take_nmi <= next_take_nmi;
            wake_resume   <= next_resume;
            sleep_ignored <= state == LPMC_RUN && sleep_req && pending_any; // [R15]
        end
    end

    // clock gating: cpu frozen while asleep, oscillator only off in stop
    // trade-off: oscillator stays on through settle, costing power for a clean restart
    wire asleep = state == LPMC_WAIT || state == LPMC_STOP || state == LPMC_SETTLE;
    // enables follow next_state so they switch on the edge the state does
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_clk_en    <= 1'b1;                                        // [R1]
            periph_clk_en <= 1'b1;
            osc_en        <= 1'b1;
            wdg_freeze    <= 1'b0;
        end else begin
            cpu_clk_en    <= !(next_state != LPMC_RUN && next_state != LPMC_WAKE); // [R2] [R3]
            periph_clk_en <= next_state != LPMC_STOP && next_state != LPMC_SETTLE; // [R4] [R6]
            osc_en        <= next_state != LPMC_STOP;                     // [R4] [R6]
            wdg_freeze    <= next_state == LPMC_STOP || next_state == LPMC_SETTLE; // [R9]
        end
    end
    // auxiliary oscillator select follows the software bit in run and wait
    // dropped in stop so no slow clock runs while the oscillators are off
    assign low_freq_aux_oscillator = ctrl[`LPMC_CTRL_AUX_BIT] && state != LPMC_STOP; // [R16]

    // register writes; clearing global enable masks every maskable source
    // writes never stall; a write without lane 0 enabled is dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl   <= `LPMC_CTRL_RESET;
            option <= `LPMC_OPTION_RESET;
            irqcfg <= `LPMC_IRQCFG_RESET;
        end else if (wr_lane0) begin
            if (sel_ctrl) begin
                ctrl <= lane_merge(ctrl, avs_writedata, 1'b1) & 8'h03;    // [R17]
            end else if (sel_option) begin
                option <= lane_merge(option, avs_writedata, 1'b1) & 8'h01;
            end else if (sel_irqcfg) begin
                irqcfg <= lane_merge(irqcfg, avs_writedata, 1'b1);
            end
        end
    end

    // read data registered; waitrequest holds reads one cycle
    // status is read-only, writes to it are ignored
    // unmapped offsets read as zero
    wire [7:0] status_val = {1'b0, pending_stop, sleep_ctx, asleep, state};
    wire [7:0] rd_mux = sel_ctrl   ? ctrl :
                        sel_status ? status_val :
                        sel_option ? option :
                        sel_irqcfg ? irqcfg : 8'h00;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_ack       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_ack       <= avs_read && !rd_ack;
            avs_readdata <= avs_read ? {24'h00_0000, rd_mux} : avs_readdata;
        end
    end
    // combinational, so the first read cycle stalls without losing an edge
    assign avs_waitrequest = avs_read && !rd_ack;
endmodule

/* bench/lpmc_irq_model.sv */
// interrupt source model: requests latched until the core fetches a vector
`timescale 1ns/1ps
module lpmc_irq_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] raise,
    input  wire logic       clr,
    input  wire logic       taken,
    output logic            ext_irq,
    output logic            nmi_req,
    output logic            per_req
);
    // a request stays up until served, like an edge latch cleared on vector fetch
    always_ff @(posedge clk) begin
        if (sys_rst || clr || taken) begin
            {per_req, nmi_req, ext_irq} <= 3'b000;
        end else begin
            {per_req, nmi_req, ext_irq} <= {per_req, nmi_req, ext_irq} | raise;
        end
    end
endmodule

/* bench/lpmc_monitor.sv */
// port assertions of the low power mode controller
`timescale 1ns/1ps
module lpmc_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wait_insn,
    input wire logic stop_insn,
    input wire logic nmi_pin,
    input wire logic wdg_active,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_en,
    input wire logic wdg_freeze,
    input wire logic wake_pulse,
    input wire logic wake_take_irq,
    input wire logic wake_take_nmi,
    input wire logic wake_resume,
    input wire logic sleep_ignored
);
    logic [12:0] settle_cnt;
    logic [4:0]  pin_low;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // settling cycles; pin history covers the synchroniser lag
    always_ff @(posedge clk) begin
        settle_cnt <= (sys_rst || !(osc_en && wdg_freeze)) ? 13'h0 : settle_cnt + 13'h1;
        pin_low    <= {pin_low[3:0], !nmi_pin};
    end
    sequence s_restart;
        cpu_clk_en ##1 wake_pulse;
    endsequence
    a_reset_run: assert property (disable iff (1'b0) sys_rst |=> cpu_clk_en && periph_clk_en && osc_en)
        else $error("not running after reset");
    a_wake_follows: assert property ($rose(cpu_clk_en) |-> s_restart)
        else $error("no wake pulse after clock return");
    a_settle_len: assert property ($rose(cpu_clk_en) && $past(wdg_freeze) |-> settle_cnt >= 13'h7fe && settle_cnt <= 13'h802)
        else $error("settling delay wrong");
    a_wait_clocks: assert property (!cpu_clk_en && !wdg_freeze |-> periph_clk_en && osc_en)
        else $error("clock lost in wait");
    a_stop_clocks: assert property (!osc_en |-> !cpu_clk_en && !periph_clk_en && wdg_freeze)
        else $error("clock running in stop");
    a_wdg_subst: assert property (stop_insn && wdg_active && (&pin_low) && !nmi_pin |=> osc_en [*3])
        else $error("stop taken with watchdog on");
    a_refuse_hold: assert property (sleep_ignored |-> $past(wait_insn || stop_insn) && cpu_clk_en ##1 cpu_clk_en)
        else $error("refused sleep not kept running");
    a_sleep_enter: assert property ((wait_insn || stop_insn) && cpu_clk_en |-> ##[1:2] (!cpu_clk_en || sleep_ignored))
        else $error("sleep not entered");
    a_restart_one: assert property (wake_pulse |-> $onehot({wake_take_irq, wake_take_nmi, wake_resume}))
        else $error("restart choice not unique");
    a_flags_pulse: assert property (wake_take_irq || wake_take_nmi || wake_resume |-> wake_pulse)
        else $error("restart flag without wake");
endmodule
bind lpmc_core lpmc_monitor u_lpmc_monitor (.clk(clk), .sys_rst(sys_rst), .wait_insn(wait_insn),
    .stop_insn(stop_insn), .nmi_pin(nmi_pin), .wdg_active(wdg_active), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_en(osc_en), .wdg_freeze(wdg_freeze), .wake_pulse(wake_pulse),
    .wake_take_irq(wake_take_irq), .wake_take_nmi(wake_take_nmi), .wake_resume(wake_resume),
    .sleep_ignored(sleep_ignored));

/* bench/tb.sv */
// bench: register access, sleep entry, wake sources and restart context
`timescale 1ns/1ps
`include "lpmc_map.svh"
module tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wreq, wait_insn = 1'b0, stop_insn = 1'b0, nmi_pin = 1'b0, wdg_active = 1'b0, clr = 1'b0;
    logic [1:0]  cpu_ctx = 2'b00;
    logic [3:0]  per_ext_clk = 4'h0;
    logic [2:0]  raise = 3'b000;
    logic        ext_irq, nmi_req, per_req, cpu_en, per_en, osc_en, aux, frz, wake, t_irq, t_nmi, resume, ign;
    int          mismatches = 0;
    int          checks_done = 0;
    // case table, entry i in slice i: stop?, context, source, expected {ign, irq, nmi, resume}
    localparam logic [5:0]  STP = 6'b101010;
    localparam logic [11:0] CTX = 12'b00_01_01_10_00_00;
    localparam logic [17:0] SRC = {3'h4, 3'h2, 3'h1, 3'h1, 3'h2, 3'h1};
    localparam logic [23:0] EXP = 24'h421124;
    always #5 clk = ~clk;
    lpmc_core u_lpmc_core (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .wait_insn(wait_insn), .stop_insn(stop_insn), .cpu_ctx(cpu_ctx), .nmi_req(nmi_req), .nmi_pin(nmi_pin),
        .ext_irq(ext_irq), .per_irq({3'b000, per_req}), .per_ext_clk(per_ext_clk), .wdg_active(wdg_active),
        .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .osc_en(osc_en), .low_freq_aux_oscillator(aux),
        .wdg_freeze(frz), .wake_pulse(wake), .wake_take_irq(t_irq), .wake_take_nmi(t_nmi),
        .wake_resume(resume), .sleep_ignored(ign));
    lpmc_irq_model u_lpmc_irq_model (.clk(clk), .sys_rst(sys_rst), .raise(raise), .clr(clr), .taken(wake),
        .ext_irq(ext_irq), .nmi_req(nmi_req), .per_req(per_req));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // one-cycle pulses of the sleep instructions and the source raise lines
    task automatic pulse(input logic s, input logic w, input logic [2:0] src);
        @(posedge clk);
        stop_insn <= s;
        wait_insn <= w;
        raise <= src;
        @(posedge clk);
        stop_insn <= 1'b0;
        wait_insn <= 1'b0;
        raise <= 3'b000;
    endtask
    // stops at the first wake or refusal pulse; n = lim + 1 means none came
    task automatic watch(input int lim, output int n, output logic [3:0] seen);
        seen = 4'h0;
        for (n = 1; n <= lim; n++) begin
            @(posedge clk);
            seen = {ign, t_irq, t_nmi, resume};
            if (wake === 1'b1 || ign === 1'b1) break;
        end
    endtask
    task automatic setup();
        logic [31:0] q;
        bus(1'b1, `LPMC_OFS_IRQCFG, 8'h11, q);
        bus(1'b1, `LPMC_OFS_OPTION, 8'h01, q);
        bus(1'b1, `LPMC_OFS_CTRL, 8'h03, q); // aux oscillator and global enable on
        bus(1'b0, `LPMC_OFS_IRQCFG, 8'h00, q);
        chk(q, 32'h11, "irqcfg"); // source enables read back
    endtask
    // watchdog: the whole sequence needs about 10.5k cycles
    initial begin
        #600000;
        mismatches++;
        complete_run();
    end
    initial begin
        logic [31:0] q;
        logic [3:0]  seen;
        int          n;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        chk({cpu_en, per_en, osc_en}, 3'b111, "reset state"); // run clocks after reset
        bus(1'b0, 4'h2, 8'h00, q);
        chk(q, 32'h0, "unmapped"); // unmapped offset reads zero
        setup();
        for (int i = 0; i < 6; i++) begin
            cpu_ctx <= CTX[2*i +: 2];
            per_ext_clk <= 4'h1;
            pulse(STP[i], !STP[i], 3'b000);
            repeat (3) @(posedge clk);
            chk({cpu_en, per_en, osc_en, aux}, STP[i] ? 4'h0 : 4'h7, "sleep clocks"); // asleep
            pulse(1'b0, 1'b0, SRC[3*i +: 3]);
            watch(2100, n, seen);
            chk(STP[i] ? (n >= 2049 && n <= 2056) : (n >= 2 && n <= 5), 1, "wake time"); // delay
            chk(seen, EXP[4*i +: 4], "restart"); // context choice
        end
        bus(1'b0, `LPMC_OFS_CTRL, 8'h00, q);
        chk(q, 32'h3, "ctrl kept"); // kept over sleep
        pulse(1'b0, 1'b0, 3'b001);
        pulse(1'b0, 1'b1, 3'b000);
        watch(6, n, seen);
        chk({seen, cpu_en}, 5'h11, "refused"); // pending request refuses sleep
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        bus(1'b1, `LPMC_OFS_CTRL, 8'h00, q);
        pulse(1'b0, 1'b1, 3'b011);
        watch(30, n, seen);
        chk(n, 31, "masked wake"); // no wake without global enable
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(cpu_en, 1'b1, "reset exit"); // reset leaves wait
        setup();
        per_ext_clk <= 4'h0;
        pulse(1'b1, 1'b0, 3'b100);
        watch(30, n, seen);
        chk(n, 31, "internal clock peripheral"); // no stop exit
        pulse(1'b0, 1'b0, 3'b001);
        watch(2100, n, seen);
        wdg_active <= 1'b1;
        pulse(1'b1, 1'b0, 3'b000);
        repeat (3) @(posedge clk);
        chk({cpu_en, osc_en, frz}, 3'b010, "stop as wait"); // watchdog substitutes wait
        pulse(1'b0, 1'b0, 3'b001);
        watch(30, n, seen);
        chk(n <= 5, 1, "wait exit"); // no settling
        nmi_pin <= 1'b1;
        repeat (6) @(posedge clk);
        pulse(1'b1, 1'b0, 3'b000);
        repeat (3) @(posedge clk);
        chk({cpu_en, osc_en, frz}, 3'b001, "override stop"); // stop with watchdog frozen
        pulse(1'b0, 1'b0, 3'b001);
        watch(2100, n, seen);
        chk(n >= 2049 && n <= 2056, 1, "override wake"); // settling delay
        complete_run();
    end
endmodule
